// File: verif/rss_pins.sv
// partner model: input terminals, stop key, trip and low bus pins
`timescale 1ns/1ps
module rss_pins (
  input  wire logic       clk_i,
  input  wire logic [6:0] want_i,
  output logic      [6:0] pins_o = 7'h00
);
  // ****************************************
  // pins change just after a rising edge
  // ****************************************
  logic [2:0] held_r = 3'h0;
  always @(posedge clk_i) begin
    // a key press is held a few cycles, as a finger would hold it
    if (held_r != 3'h0) held_r <= held_r - 3'h1;
    else pins_o <= want_i;
    if (want_i[3] && !pins_o[3] && held_r == 3'h0) held_r <= 3'h4;
  end
endmodule // rss_pins

// File: verif/testbench.sv
// testbench: bus tasks, note queue, scoreboard and scenarios for the run/stop sequencer
`timescale 1ns/1ps
module testbench;
  import rss_pkg::*;
  typedef struct {logic [31:0] e; logic [31:0] m; int k;} rss_note_t;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, tr_n = 32'h0000_0000, n0, e, ev;
  logic        wb_ack_o, irq_o, inverter_active_o, run_o, reverse_o, trip_reset_o, pend = 1'b0;
  logic        standstill_i = 1'b1, term_a_i, term_b_i, term_c_i, stop_key_i, safe_torque_i, trip_i, low_bus_i;
  logic [15:0] motor_speed_i = 16'h0000, ref_i = 16'h0000, post_ramp_reference_o, spd;
  logic [6:0]  want = 7'h00, pins;
  integer      seed = 32'h408d_4714, error_cnt = 0, tests_run = 0;
  rss_note_t   q[$], nt;
  assign {low_bus_i, trip_i, safe_torque_i, stop_key_i, term_c_i, term_b_i, term_a_i} = pins;
  always #2 clk_i = ~clk_i;
  rss_pins i_pins (.clk_i(clk_i), .want_i(want), .pins_o(pins));
  rss_seq #(.SPD_W(16), .REV_BOTH_CNT(20)) i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .term_a_i, .term_b_i, .term_c_i,
    .stop_key_i, .safe_torque_i, .trip_i, .low_bus_i, .standstill_i, .motor_speed_i, .ref_i,
    .post_ramp_reference_o, .inverter_active_o, .run_o, .reverse_o, .trip_reset_o);
  // ********************
  // scoreboard
  // ********************
  always @(posedge clk_i) if (trip_reset_o === 1'b1) tr_n <= tr_n + 32'h0000_0001;
  function automatic logic [31:0] pick(input int k);
    case (k)
      0: pick = {31'h0, run_o};
      1: pick = {31'h0, inverter_active_o};
      2: pick = {16'h0, post_ramp_reference_o};
      3: pick = {31'h0, reverse_o};
      4: pick = {31'h0, irq_o};
      5: pick = tr_n;
      default: pick = {31'h0, post_ramp_reference_o < 16'h0020};
    endcase
  endfunction
  always @(posedge clk_i) begin
    if (((wb_ack_o === 1'b1 && wb_we_i === 1'b0) || pend) && q.size() > 0) begin
      nt = q.pop_front();
      e = pend ? pick(nt.k) : wb_dat_o;
      tests_run++;
      if ((e & nt.m) !== (nt.e & nt.m)) begin
        error_cnt++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, e & nt.m, nt.e & nt.m);
      end
    end
  end
  // ********************
  // tasks
  // ********************
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= w ? d : 32'h0000_0000;
    wb_sel_i <= 4'hf;
    if (!w) q.push_back('{d, m, 9});
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      report_and_stop();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0000_0000);
  endtask
  task automatic chk(input int k, input logic [31:0] x);
    q.push_back('{x, 32'hffff_ffff, k});
    pend <= 1'b1;
    @(posedge clk_i);
    pend <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic press;
    want[3] <= 1'b1;
    tick(8);
    want[3] <= 1'b0;
    tick(10);
  endtask
  task automatic restart;
    want[1] <= 1'b0;
    tick(8);
    want[1] <= 1'b1;
    tick(8);
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    report_and_stop();
  end
  // ********************
  // scenarios
  // ********************
  initial begin
    tick(10);
    rst_i <= 1'b0;
    bus(1'b0, ADDR_CTRL, CTRL_RESET, 32'h0000_01ff);
    bus(1'b0, ADDR_USER, USR_RESET, 32'h0000_007f);
    wr(8'h14, 32'hffff_ffff);
    bus(1'b0, 8'h14, 32'h0000_0000, 32'hffff_ffff);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CTRL, 32'h0000_0090 | s);
      for (int t = 0; t < 16; t++) begin
        want <= {2'b00, ~t[3], 1'b0, t[2:0]};
        tick(6);
        ev = {24'h0, s[0], s[0] & t[0], t[2], t[1], ~t[3] & (s[0] | t[0]), 3'h0};
        bus(1'b0, ADDR_STATUS, ev, {24'h0, 1'b1, s[0], ~s[1], ~s[1], 4'h8});
        if (s > 1 && t[1] && !t[3]) chk(3, t[2]);
      end
    end
    wr(ADDR_USER, 32'h0000_0009);
    wr(ADDR_CTRL, 32'h0000_0094);
    want <= 7'h13;
    tick(8);
    bus(1'b0, ADDR_STATUS, 32'h0000_0070, 32'h0000_00f0);
    wr(ADDR_CTRL, 32'h0000_0090);
    tick(8);
    chk(0, 1);
    want[1] <= 1'b0;
    standstill_i <= 1'b1;
    tick(8);
    bus(1'b0, ADDR_STATUS, 32'h0000_0003, 32'h0000_0007);
    chk(1, 1);
    chk(4, 0);
    wr(ADDR_IRQ_MSK, 32'h0000_0008);
    chk(4, 1);
    wr(ADDR_IRQ_ST, 32'h0000_0008);
    chk(4, 0);
    wr(ADDR_CTRL, 32'h0000_0080);
    tick(4);
    bus(1'b0, ADDR_STATUS, 32'h0000_0000, 32'h0000_0007);
    chk(1, 0);
    spd = 16'($random(seed));
    motor_speed_i <= spd;
    ref_i <= spd;
    wr(ADDR_CTRL, 32'h0000_00a0);
    want[1] <= 1'b1;
    standstill_i <= 1'b0;
    tick(8);
    chk(2, {16'h0, spd});
    want[1] <= 1'b0;
    standstill_i <= 1'b1;
    tick(8);
    wr(ADDR_CTRL, 32'h0000_0080);
    ref_i <= spd | 16'h8000;
    want[1] <= 1'b1;
    standstill_i <= 1'b0;
    tick(8);
    chk(6, 1);
    wr(ADDR_CTRL, 32'h0000_00c0);
    press();
    chk(0, 0);
    standstill_i <= 1'b1;
    bus(1'b0, ADDR_STATUS, 32'h0000_0100, 32'h0000_0100);
    restart();
    bus(1'b0, ADDR_STATUS, 32'h0000_0000, 32'h0000_0100);
    wr(ADDR_CTRL, 32'h0000_0180);
    press();
    chk(0, 0);
    restart();
    wr(ADDR_CTRL, 32'h0000_0080);
    press();
    chk(0, 1);
    wr(ADDR_CTRL, 32'h0000_0000);
    tick(8);
    chk(0, 0);
    wr(ADDR_CTRL, 32'h0000_0080);
    tick(8);
    chk(0, 1);
    want[5] <= 1'b1;
    tick(8);
    bus(1'b0, ADDR_STATUS, 32'h0000_0004, 32'h0000_0007);
    n0 = tr_n;
    press();
    want[5] <= 1'b0;
    tick(8);
    chk(5, n0 + 32'h0000_0001);
    chk(0, 0);
    want[2] <= 1'b1;
    tick(40);
    bus(1'b0, ADDR_STATUS, 32'h0000_0000, 32'h0000_0100);
    want[2] <= 1'b0;
    tick(8);
    want[6:5] <= 2'b11;
    tick(8);
    n0 = tr_n;
    press();
    chk(5, n0);
    want[6:5] <= 2'b00;
    tick(8);
    chk(0, 1);
    report_and_stop();
  end
endmodule // testbench

// File: verilog/rss_pkg.sv
// package: register map, field layout, resets and timing for the run/stop sequencer
package rss_pkg;
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned REV_BOTH_MS     = 60;
  localparam int unsigned REV_BOTH_CYC    = CLK_HZ / 1000 * REV_BOTH_MS;
  localparam int unsigned KEY_SYNC_STAGES = 2;

  // register word byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h0C;
  localparam logic [7:0] ADDR_USER    = 8'h10;

  // ctrl fields
  localparam int unsigned CTRL_SEL_LSB = 0;
  localparam int unsigned CTRL_SEL_W   = 3;
  localparam int unsigned CTRL_HZS     = 4;
  localparam int unsigned CTRL_TRACK   = 5;
  localparam int unsigned CTRL_STOPKEY = 6;
  localparam int unsigned CTRL_DRVEN   = 7;
  localparam int unsigned CTRL_KEYPAD  = 8;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0094;

  // user routing fields (selectors 4 to 7)
  localparam int unsigned USR_A_LSB = 0;
  localparam int unsigned USR_B_LSB = 2;
  localparam int unsigned USR_C_LSB = 4;
  localparam int unsigned USR_LATCH = 6;
  localparam logic [31:0] USR_RESET = 32'h0000_0000;

  // interrupt events
  localparam int unsigned IRQ_W       = 4;
  localparam int unsigned EV_LOCKOUT  = 0;
  localparam int unsigned EV_TRIPCLR  = 1;
  localparam int unsigned EV_RELEASE  = 2;
  localparam int unsigned EV_STANDBY  = 3;

  typedef enum logic [2:0] {
    RSS_ST_READY  = 3'b000,
    RSS_ST_RUN    = 3'b001,
    RSS_ST_STOP   = 3'b010,
    RSS_ST_HOLD   = 3'b011,
    RSS_ST_TRIP   = 3'b100
  } rss_state_t;

  // user destinations for a terminal
  localparam logic [1:0] DST_NONE   = 2'h0;
  localparam logic [1:0] DST_FWD    = 2'h1;
  localparam logic [1:0] DST_REV    = 2'h2;
  localparam logic [1:0] DST_NHALT  = 2'h3;
endpackage

// File: verilog/rss_seq.sv
// run/stop sequencer with terminal routing, stop-key lockout and wishbone registers
//
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
// How it works
// RL1: selector 0/1 gives fwd/rev from terminals b/c; 2/3 gives run and direction.
// RL2: selector 1/3 sends terminal a to not-halt, latching on; 0/2 to enable, off.
// RL3: hardware enable follows safe torque off, optionally ANDed with routed terminal a.
// RL4: hold zero speed keeps the inverter active after run removal at standstill.
// RL5: with hold zero speed and the drive enabled, standstill enters active hold state, not ready.
// RL6: enable with tracking off starts post-ramp reference at zero, then ramps.
// RL7: enable with tracking on loads post-ramp reference with measured speed.
// RL8: stop-key enable bit makes a stop key press always stop the motor.
// RL9: in keypad mode the stop key is always enabled regardless of that bit.
// RL10: a stop key press never takes the drive from stopped to running.
// RL11: stop key while tripped clears the trip and leaves the drive stopped.
// RL12: low bus trip ignores stop key and clears when bus voltage recovers.
// RL13: qualifying stop press without latching removes sequencer run until released.
// RL14: release on no run bits, disabled, fwd and rev for 60 ms, or low bus.
// RL15: selectors 0 to 3 force routing and latching; 4 to 7 use user routing.
// RL16: the drive runs only while software drive enable is one.
// RL17: run blocking lives in one lockout flop, set by press, cleared by release.
module rss_seq
  import rss_pkg::*;
#(
  parameter int unsigned SPD_W        = 16,
  parameter int unsigned REV_BOTH_CNT = REV_BOTH_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  irq_o,
  input  wire logic             term_a_i,
  input  wire logic             term_b_i,
  input  wire logic             term_c_i,
  input  wire logic             stop_key_i,
  input  wire logic             safe_torque_i,
  input  wire logic             trip_i,
  input  wire logic             low_bus_i,
  input  wire logic             standstill_i,
  input  wire logic [SPD_W-1:0] motor_speed_i,
  input  wire logic [SPD_W-1:0] ref_i,
  output logic      [SPD_W-1:0] post_ramp_reference_o,
  output logic                  inverter_active_o,
  output logic                  run_o,
  output logic                  reverse_o,
  output logic                  trip_reset_o
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [6:0] pins_s;
  rss_sync #(.W(7)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({term_a_i, term_b_i, term_c_i, stop_key_i, safe_torque_i, trip_i, low_bus_i}),
    .q_o   (pins_s)
  );
  logic ta, tb, tc, key, sto, trip, lowbus;
  assign {ta, tb, tc, key, sto, trip, lowbus} = pins_s;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [31:0]      ctrl;
    logic [31:0]      usr;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_msk;
    logic             ack;
    logic [31:0]      rdat;
    rss_state_t       st;
    logic             key_d;
    logic             lockout;
    logic [31:0]      both_cnt;
    logic [SPD_W-1:0] pref;
    logic             trip_rst;
  } rss_regs_t;
  rss_regs_t q_r, q_nxt;

  logic [2:0] sel;
  logic       fwd, rev, nhalt, en_term, latch, hw_en, drv_en, enabled;
  logic       key_press, key_live, both, release_c, seq_run, run_req;
  logic       wr, rd_hit;

  // ****************************************************************
  // terminal routing
  // ****************************************************************
  always_comb begin
    sel     = q_r.ctrl[CTRL_SEL_LSB +: CTRL_SEL_W];
    fwd     = 1'b0;
    rev     = 1'b0;
    nhalt   = 1'b1;
    en_term = 1'b1;
    latch   = 1'b0;
    case (sel)
      3'h0, 3'h1, 3'h2, 3'h3: begin // RL15
        if (sel[1]) begin // RL1
          fwd = tb & ~tc;
          rev = tb & tc;
        end else begin
          fwd = tb;
          rev = tc;
        end
        if (sel[0]) begin // RL2
          nhalt = ta;
          latch = 1'b1;
        end else begin
          en_term = ta;
        end
      end
      default: begin // RL15
        latch = q_r.usr[USR_LATCH];
        if (q_r.usr[USR_A_LSB +: 2] == DST_NHALT) nhalt = ta;
        if (q_r.usr[USR_A_LSB +: 2] == DST_FWD) fwd = ta;
        if (q_r.usr[USR_B_LSB +: 2] == DST_FWD) fwd = fwd | tb;
        if (q_r.usr[USR_B_LSB +: 2] == DST_REV) rev = tb;
        if (q_r.usr[USR_C_LSB +: 2] == DST_REV) rev = rev | tc;
      end
    endcase
  end

  assign hw_en   = sto & en_term;                          // RL3
  assign drv_en  = q_r.ctrl[CTRL_DRVEN];
  assign enabled = hw_en & drv_en;                         // RL16
  assign key_press = key & ~q_r.key_d;
  assign key_live  = q_r.ctrl[CTRL_STOPKEY] | q_r.ctrl[CTRL_KEYPAD]; // RL8 RL9
  assign both      = fwd & rev;
  assign release_c = (~fwd & ~rev) | ~enabled | lowbus     // RL14
                   | (q_r.both_cnt >= REV_BOTH_CNT)
                   | (latch & ~nhalt);
  assign seq_run = (fwd ^ rev) & nhalt & ~q_r.lockout;     // RL13
  assign run_req = seq_run & enabled & ~trip & ~lowbus;

  assign wr     = wb_cyc_i & wb_stb_i & wb_we_i & ~q_r.ack;
  assign rd_hit = wb_cyc_i & wb_stb_i & ~q_r.ack;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    q_nxt          = q_r;
    q_nxt.key_d    = key;
    q_nxt.trip_rst = 1'b0;
    q_nxt.ack      = rd_hit;
    // bus
    if (wr) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          case (wb_adr_i)
            ADDR_CTRL:    q_nxt.ctrl[b*8 +: 8] = wb_dat_i[b*8 +: 8];
            ADDR_USER:    q_nxt.usr[b*8 +: 8]  = wb_dat_i[b*8 +: 8];
            default: ;
          endcase
        end
      end
      if (wb_adr_i == ADDR_IRQ_MSK && wb_sel_i[0])
        q_nxt.irq_msk = wb_dat_i[IRQ_W-1:0];
      if (wb_adr_i == ADDR_IRQ_ST && wb_sel_i[0])
        q_nxt.irq_st = q_r.irq_st & ~wb_dat_i[IRQ_W-1:0];
    end
    q_nxt.rdat = 32'h0000_0000;
    if (rd_hit) begin
      case (wb_adr_i)
        ADDR_CTRL:    q_nxt.rdat = q_r.ctrl;
        ADDR_USER:    q_nxt.rdat = q_r.usr;
        ADDR_IRQ_ST:  q_nxt.rdat = {{(32-IRQ_W){1'b0}}, q_r.irq_st};
        ADDR_IRQ_MSK: q_nxt.rdat = {{(32-IRQ_W){1'b0}}, q_r.irq_msk};
        ADDR_STATUS:  q_nxt.rdat = {23'h00_0000, q_r.lockout, latch, nhalt, rev, fwd, hw_en, q_r.st};
        default:      q_nxt.rdat = 32'h0000_0000;
      endcase
    end
    // both-run timer
    if (both) begin
      if (q_r.both_cnt < REV_BOTH_CNT) q_nxt.both_cnt = q_r.both_cnt + 32'h0000_0001; // RL14
    end else begin
      q_nxt.both_cnt = 32'h0000_0000;
    end
    // lockout flop; press wins over release in the same cycle
    if (release_c) q_nxt.lockout = 1'b0;                   // RL17
    if (key_press & ~latch & (key_live | trip)) begin
      q_nxt.lockout = 1'b1;                                // RL13 RL17
      q_nxt.irq_st[EV_LOCKOUT] = 1'b1;
    end
    if (q_r.lockout & release_c) q_nxt.irq_st[EV_RELEASE] = 1'b1;
    // trip reset from stop key; low bus trip is not user clearable
    if (key_press & trip & ~lowbus) begin                  // RL11 RL12
      q_nxt.trip_rst = 1'b1;
      q_nxt.irq_st[EV_TRIPCLR] = 1'b1;
    end
    // sequencer
    case (q_r.st)
      RSS_ST_READY, RSS_ST_HOLD: begin
        if (trip | lowbus) q_nxt.st = RSS_ST_TRIP;
        else if (run_req & ~key_press) begin               // RL10
          q_nxt.st = RSS_ST_RUN;
          q_nxt.pref = q_r.ctrl[CTRL_TRACK] ? motor_speed_i : {SPD_W{1'b0}}; // RL6 RL7
        end else if ((q_r.st == RSS_ST_HOLD) & ~(q_r.ctrl[CTRL_HZS] & enabled)) begin
          // hold only lasts while zero-speed hold is on and the drive is enabled
          q_nxt.st = RSS_ST_READY;                         // RL4 RL16
        end
      end
      RSS_ST_RUN: begin
        if (trip | lowbus) q_nxt.st = RSS_ST_TRIP;
        else if (~run_req | (key_press & key_live)) q_nxt.st = RSS_ST_STOP; // RL8
        else if (q_r.pref < ref_i) q_nxt.pref = q_r.pref + {{(SPD_W-1){1'b0}}, 1'b1}; // RL6
        else if (q_r.pref > ref_i) q_nxt.pref = q_r.pref - {{(SPD_W-1){1'b0}}, 1'b1};
      end
      RSS_ST_STOP: begin
        q_nxt.pref = {SPD_W{1'b0}};
        if (trip | lowbus) q_nxt.st = RSS_ST_TRIP;
        else if (standstill_i) begin
          q_nxt.st = (q_r.ctrl[CTRL_HZS] & enabled) ? RSS_ST_HOLD : RSS_ST_READY; // RL4 RL5
          q_nxt.irq_st[EV_STANDBY] = 1'b1;
        end
      end
      RSS_ST_TRIP: begin
        q_nxt.pref = {SPD_W{1'b0}};
        if (~trip & ~lowbus) q_nxt.st = RSS_ST_READY;      // RL11 RL12
      end
      default: q_nxt.st = RSS_ST_READY;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r          <= '0;
      q_r.ctrl     <= CTRL_RESET;
      q_r.usr      <= USR_RESET;
      q_r.st       <= RSS_ST_READY;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign wb_ack_o              = q_r.ack;
  assign wb_dat_o              = q_r.rdat;
  assign irq_o                 = |(q_r.irq_st & q_r.irq_msk);
  assign post_ramp_reference_o = q_r.pref;
  assign run_o                 = (q_r.st == RSS_ST_RUN);
  assign reverse_o             = rev;
  assign inverter_active_o     = (q_r.st == RSS_ST_RUN) | (q_r.st == RSS_ST_STOP)
                               | (q_r.st == RSS_ST_HOLD);  // RL4
  assign trip_reset_o          = q_r.trip_rst;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_key_no_start: assert property (@(posedge clk_i) disable iff (rst_i) // RL10
    (q_r.st != RSS_ST_RUN) && key_press |=> (q_r.st != RSS_ST_RUN))
    else $error("stop key started the drive");
  chk_lock_set: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
    key_press && !latch && (key_live || trip) |=> q_r.lockout)
    else $error("lockout not set by stop key");
  chk_lock_blocks: assert property (@(posedge clk_i) disable iff (rst_i) // RL17
    q_r.lockout |=> (q_r.st != RSS_ST_RUN))
    else $error("run passed while locked out");
  chk_lock_release: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
    release_c && !key_press |=> !q_r.lockout)
    else $error("lockout not released");
  chk_lowbus_noclr: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
    lowbus |=> !q_r.trip_rst)
    else $error("low bus trip reset by key");
  chk_hold_entry: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
    (q_r.st == RSS_ST_STOP) && standstill_i && !trip && !lowbus && q_r.ctrl[CTRL_HZS] && enabled
    |=> (q_r.st == RSS_ST_HOLD) && inverter_active_o)
    else $error("hold state not entered");
  chk_track_load: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
    $changed(q_r.st) && (q_r.st == RSS_ST_RUN) && q_r.ctrl[CTRL_TRACK]
    |-> post_ramp_reference_o == $past(motor_speed_i))
    else $error("reference not loaded with speed");
  chk_zero_start: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
    $changed(q_r.st) && (q_r.st == RSS_ST_RUN) && !q_r.ctrl[CTRL_TRACK]
    |-> post_ramp_reference_o == {SPD_W{1'b0}})
    else $error("reference not started at zero");
  chk_drv_disable: assert property (@(posedge clk_i) disable iff (rst_i) // RL16
    !drv_en && (q_r.st == RSS_ST_RUN) |=> (q_r.st != RSS_ST_RUN))
    else $error("ran while disabled");
  chk_route_latch: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
    (sel == 3'h1 || sel == 3'h3) |-> latch && (nhalt == ta))
    else $error("latch routing wrong");

  // ****************************************************************
  // rule checks: routing, stopping, trips, release
  // ****************************************************************
  chk_route_fwdrev: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
    (sel == 3'h0 || sel == 3'h1) |-> (fwd == tb) && (rev == tc))
    else $error("forward reverse routing wrong");
  chk_route_dir: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
    (sel == 3'h2 || sel == 3'h3) |-> (fwd == (tb && !tc)) && (rev == (tb && tc)))
    else $error("run direction routing wrong");
  chk_route_enable: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
    (sel == 3'h0 || sel == 3'h2) |-> !latch && nhalt && (en_term == ta))
    else $error("enable routing wrong");
  chk_hw_enable: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
    !sto |-> !hw_en && !enabled)
    else $error("enabled without safe torque input");
  chk_hold_exit: assert property (@(posedge clk_i) disable iff (rst_i) // RL4 RL16
    (q_r.st == RSS_ST_HOLD) && !enabled && !trip && !lowbus
    |=> (q_r.st == RSS_ST_READY) && !inverter_active_o)
    else $error("hold kept while disabled");
  chk_ready_entry: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
    (q_r.st == RSS_ST_STOP) && standstill_i && !trip && !lowbus && !(q_r.ctrl[CTRL_HZS] && enabled)
    |=> (q_r.st == RSS_ST_READY) && !inverter_active_o)
    else $error("ready state not entered");
  chk_stopkey_stop: assert property (@(posedge clk_i) disable iff (rst_i) // RL8
    (q_r.st == RSS_ST_RUN) && key_press && q_r.ctrl[CTRL_STOPKEY] && !trip && !lowbus
    |=> (q_r.st == RSS_ST_STOP))
    else $error("enabled stop key did not stop");
  chk_keypad_stop: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
    (q_r.st == RSS_ST_RUN) && key_press && q_r.ctrl[CTRL_KEYPAD] && !trip && !lowbus
    |=> (q_r.st == RSS_ST_STOP))
    else $error("keypad mode stop key did not stop");
  chk_trip_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
    key_press && trip && !lowbus |=> trip_reset_o && (q_r.st == RSS_ST_TRIP))
    else $error("trip not cleared by stop key");
  chk_lowbus_trip: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
    lowbus |=> (q_r.st == RSS_ST_TRIP))
    else $error("low bus did not hold the trip");
  chk_both_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
    !both |=> (q_r.both_cnt == 32'h0000_0000))
    else $error("both-run timer not cleared");
  chk_user_latch: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
    (sel > 3'h3) |-> (latch == q_r.usr[USR_LATCH]))
    else $error("user latch routing wrong");
  chk_lock_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RL17
    q_r.lockout && !release_c |=> q_r.lockout)
    else $error("lockout dropped without release");
  chk_disable_norun: assert property (@(posedge clk_i) disable iff (rst_i) // RL16
    (q_r.st != RSS_ST_RUN) && !enabled |=> (q_r.st != RSS_ST_RUN))
    else $error("started while disabled");
  chk_ramp_up: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
    (q_r.st == RSS_ST_RUN) && run_req && !key_press && (q_r.pref < ref_i)
    |=> post_ramp_reference_o == $past(q_r.pref) + {{(SPD_W-1){1'b0}}, 1'b1})
    else $error("reference did not ramp up");
endmodule // rss_seq

// File: verilog/rss_sync.sv
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module rss_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d_i;
      q_r    <= meta_r;
    end
  end
  assign q_o = q_r;
endmodule // rss_sync
